// ### core/vpmap_pkg.sv
package vpmap_pkg;
  localparam logic [1:0] OP0_SYS = 2'h3;
  localparam logic [2:0] OP1_HYP = 3'h4;
  localparam logic [3:0] CRN_PART = 4'ha;
  localparam logic [3:0] CRM_TOP_MAP = 4'h6;
  localparam logic [2:0] OP2_TOP_MAP = 3'h7;
  localparam logic [3:0] CRM_VALID = 4'h4;
  localparam logic [2:0] OP2_VALID = 3'h1;
  localparam logic [11:0] NESTED_VIRT_MEMORY_OFS_TOP_MAP = 12'h978;
  localparam logic [11:0] NESTED_VIRT_MEMORY_OFS_VALID = 12'h938;
  localparam logic [5:0] SYND_CLASS_SYSREG = 6'h18;
  localparam int VALID_BITS = 32;
  localparam int FIELD_W = 16;
  localparam int TOP_BASE_ID = 28;
  localparam int IDS_PER_REG = 4;
  localparam logic [4:0] TOP_REG_INDEX = 5'h07;
  typedef enum logic [1:0] {
    VPM_EL0 = 2'b00,
    VPM_EL1 = 2'b01,
    VPM_EL2 = 2'b10,
    VPM_EL3 = 2'b11
  } vpm_level_t;
  typedef enum logic [2:0] {
    VPM_RES_DONE = 3'b000,
    VPM_RES_UNDEF = 3'b001,
    VPM_RES_MEM = 3'b010,
    VPM_RES_TRAP2 = 3'b011,
    VPM_RES_TRAP3 = 3'b100
  } vpm_result_t;
endpackage

// ### core/vpm_valid_store.sv
// keeps the 32 valid bits; no reset on purpose, contents start unknown
module vpm_valid_store #(
  parameter int WIDTH = 32
) (
  input wire logic core_clk_i,
  input wire logic wr_en_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  output logic [WIDTH-1:0] rd_data_o
);
  logic [WIDTH-1:0] bits_reg;
  logic [WIDTH-1:0] bits_next;
  always_comb begin
    bits_next = wr_en_i ? wr_data_i : bits_reg;
  end
  always_ff @(posedge core_clk_i) begin
    bits_reg <= bits_next;
  end
  assign rd_data_o = bits_reg;
endmodule

// ### core/vpm_access.sv
// Function
// - decode top mapping register at op0 3, op1 4, CRn 10, CRm 6, op2 7
// - decode valid register at op0 3, op1 4, CRn 10, CRm 4, op2 1
// - level zero access is undefined and changes nothing
// - level one with both nested bits goes to memory at 0x978 or 0x938
// - level one nested only traps class 0x18 to level three or two
// - level two traps to level three if trap bit set, else direct
// - level three always reads or writes directly
// - valid bit m qualifies entry m held in mapping register m>>2
// - valid register bits 0..31 hold valid bits, upper half reads zero
// - valid bits reset to unknown, software initialises them
// - valid register exists only with extension and hyp control flag
// - valid bits ignored when level two not enabled
// - valid register is a 64-bit system register
// - top register holds four 16-bit ids, id 31 highest
// - mapping entry used only when its valid bit is one
// - mapping applies per level-one and level-zero enable bits
module vpm_access #(
  parameter int DATA_W = 64
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic req_i,
  input wire logic req_write_i,
  input wire logic [1:0] req_op0_i,
  input wire logic [2:0] req_op1_i,
  input wire logic [3:0] req_crn_i,
  input wire logic [3:0] req_crm_i,
  input wire logic [2:0] req_op2_i,
  input wire logic [DATA_W-1:0] req_wdata_i,
  input wire logic [1:0] cur_level_i,
  input wire logic level2_enabled_i,
  input wire logic level3_present_i,
  input wire logic lower_level_trap_bit_i,
  input wire logic nested_virt_bit_i,
  input wire logic enhanced_nested_bit_i,
  input wire logic extension_present_i,
  input wire logic hyp_control_present_flag_i,
  input wire logic level_one_map_enable_i,
  input wire logic level_zero_map_enable_i,
  input wire logic [4:0] map_vid_i,
  input wire logic map_from_level1_i,
  output logic resp_valid_o,
  output logic [2:0] resp_result_o,
  output logic [DATA_W-1:0] resp_rdata_o,
  output logic [11:0] resp_mem_offset_o,
  output logic [5:0] resp_syndrome_o,
  output logic map_hit_o,
  output logic [15:0] map_physical_id_o
);
  logic hit_top;
  logic hit_valid;
  logic reg_present;
  logic trap3;
  logic valid_wr;
  logic acc_ok;
  logic [vpmap_pkg::VALID_BITS-1:0] valid_bits;
  logic [DATA_W-1:0] top_map_reg;
  logic [DATA_W-1:0] top_map_next;
  logic resp_valid_reg;
  logic resp_valid_next;
  vpmap_pkg::vpm_result_t resp_result_reg;
  vpmap_pkg::vpm_result_t resp_result_next;
  logic [DATA_W-1:0] resp_rdata_reg;
  logic [DATA_W-1:0] resp_rdata_next;
  logic [11:0] resp_mem_offset_reg;
  logic [11:0] resp_mem_offset_next;
  logic [5:0] resp_syndrome_reg;
  logic [5:0] resp_syndrome_next;
  logic map_hit_reg;
  logic map_hit_next;
  logic [15:0] map_physical_id_reg;
  logic [15:0] map_physical_id_next;

  function automatic logic enc_match(input logic [3:0] crm, input logic [2:0] op2);
    return req_op0_i == vpmap_pkg::OP0_SYS && req_op1_i == vpmap_pkg::OP1_HYP &&
           req_crn_i == vpmap_pkg::CRN_PART && req_crm_i == crm && req_op2_i == op2;
  endfunction

  assign hit_top = enc_match(vpmap_pkg::CRM_TOP_MAP, vpmap_pkg::OP2_TOP_MAP);
  assign hit_valid = enc_match(vpmap_pkg::CRM_VALID, vpmap_pkg::OP2_VALID);
  // both registers share the presence condition of the valid register
  assign reg_present = extension_present_i && hyp_control_present_flag_i;
  assign trap3 = level3_present_i && lower_level_trap_bit_i;
  assign acc_ok = req_i && (hit_top || hit_valid) && reg_present;

  always_comb begin
    resp_valid_next = 1'b0;
    resp_result_next = vpmap_pkg::VPM_RES_DONE;
    resp_rdata_next = '0;
    resp_mem_offset_next = '0;
    resp_syndrome_next = '0;
    top_map_next = top_map_reg;
    valid_wr = 1'b0;
    if (req_i) begin
      resp_valid_next = 1'b1;
      // refused unless a branch below accepts it
      resp_result_next = vpmap_pkg::VPM_RES_UNDEF;
      if ((hit_top || hit_valid) && reg_present) begin
        unique case (vpmap_pkg::vpm_level_t'(cur_level_i))
          vpmap_pkg::VPM_EL0: begin
            resp_result_next = vpmap_pkg::VPM_RES_UNDEF;
          end
          vpmap_pkg::VPM_EL1: begin
            if (level2_enabled_i && nested_virt_bit_i && enhanced_nested_bit_i) begin
              resp_result_next = vpmap_pkg::VPM_RES_MEM;
              resp_mem_offset_next = hit_top ? vpmap_pkg::NESTED_VIRT_MEMORY_OFS_TOP_MAP :
                                               vpmap_pkg::NESTED_VIRT_MEMORY_OFS_VALID;
            end else if (level2_enabled_i && nested_virt_bit_i) begin
              resp_result_next = trap3 ? vpmap_pkg::VPM_RES_TRAP3 :
                                         vpmap_pkg::VPM_RES_TRAP2;
              resp_syndrome_next = vpmap_pkg::SYND_CLASS_SYSREG;
            end else begin
              resp_result_next = vpmap_pkg::VPM_RES_UNDEF;
            end
          end
          vpmap_pkg::VPM_EL2, vpmap_pkg::VPM_EL3: begin
            if (cur_level_i == vpmap_pkg::VPM_EL2 && trap3) begin
              resp_result_next = vpmap_pkg::VPM_RES_TRAP3;
              resp_syndrome_next = vpmap_pkg::SYND_CLASS_SYSREG;
            end else begin
              resp_result_next = vpmap_pkg::VPM_RES_DONE;
              if (req_write_i) begin
                if (hit_top) begin
                  top_map_next = req_wdata_i;
                end else begin
                  valid_wr = 1'b1;
                end
              end else begin
                // upper half of the valid register reads zero
                resp_rdata_next = hit_top ? top_map_reg :
                                  DATA_W'(valid_bits);
              end
            end
          end
        endcase
      end
    end
  end

  // map lookup; only entries 28..31 are held here, lower ids never hit
  always_comb begin
    logic [1:0] fsel;
    logic en;
    fsel = map_vid_i[1:0];
    en = map_from_level1_i ? level_one_map_enable_i : level_zero_map_enable_i;
    map_physical_id_next = top_map_reg[fsel*vpmap_pkg::FIELD_W +: vpmap_pkg::FIELD_W];
    map_hit_next = en && level2_enabled_i &&
                   (map_vid_i[4:2] == vpmap_pkg::TOP_REG_INDEX[2:0]) &&
                   valid_bits[map_vid_i];
  end

  vpm_valid_store #(
    .WIDTH(vpmap_pkg::VALID_BITS)
  ) u_valid (
    .core_clk_i(core_clk_i),
    .wr_en_i(valid_wr),
    .wr_data_i(req_wdata_i[vpmap_pkg::VALID_BITS-1:0]),
    .rd_data_o(valid_bits)
  );

  // mapping fields carry no reset value, like the valid bits
  always_ff @(posedge core_clk_i) begin
    top_map_reg <= top_map_next;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      resp_valid_reg <= 1'b0;
      resp_result_reg <= vpmap_pkg::VPM_RES_DONE;
      resp_rdata_reg <= '0;
      resp_mem_offset_reg <= '0;
      resp_syndrome_reg <= '0;
      map_hit_reg <= 1'b0;
      map_physical_id_reg <= '0;
    end else begin
      resp_valid_reg <= resp_valid_next;
      resp_result_reg <= resp_result_next;
      resp_rdata_reg <= resp_rdata_next;
      resp_mem_offset_reg <= resp_mem_offset_next;
      resp_syndrome_reg <= resp_syndrome_next;
      map_hit_reg <= map_hit_next;
      map_physical_id_reg <= map_physical_id_next;
    end
  end

  assign resp_valid_o = resp_valid_reg;
  assign resp_result_o = resp_result_reg;
  assign resp_rdata_o = resp_rdata_reg;
  assign resp_mem_offset_o = resp_mem_offset_reg;
  assign resp_syndrome_o = resp_syndrome_reg;
  assign map_hit_o = map_hit_reg;
  assign map_physical_id_o = map_physical_id_reg;

  // answers are registered, so each check looks one cycle after the request, except a_el0_no_valid, which checks valid_wr in the same cycle
  a_resp_pulse: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    req_i
    |=> resp_valid_o)
    else $error("request got no answer");
  a_idle_quiet: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !req_i
    |=> !resp_valid_o && resp_result_o == vpmap_pkg::VPM_RES_DONE && resp_rdata_o == '0 &&
        resp_mem_offset_o == '0 && resp_syndrome_o == '0)
    else $error("answer fields not cleared when idle");
  a_unknown_enc: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    req_i && !hit_top && !hit_valid
    |=> resp_result_o == vpmap_pkg::VPM_RES_UNDEF)
    else $error("unknown encoding not undefined");
  a_el0_undef: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    req_i && cur_level_i == vpmap_pkg::VPM_EL0
    |=> resp_result_o == vpmap_pkg::VPM_RES_UNDEF)
    else $error("level zero access not undefined");
  a_el0_no_write: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    req_i && cur_level_i == vpmap_pkg::VPM_EL0
    |=> $stable(top_map_reg))
    else $error("level zero access changed register");
  a_el0_no_valid: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    req_i && cur_level_i == vpmap_pkg::VPM_EL0
    |-> !valid_wr)
    else $error("level zero access wrote valid bits");
  a_nv_mem_ofs: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    acc_ok && hit_top && cur_level_i == vpmap_pkg::VPM_EL1 && level2_enabled_i &&
    nested_virt_bit_i && enhanced_nested_bit_i
    |=> resp_result_o == vpmap_pkg::VPM_RES_MEM &&
        resp_mem_offset_o == vpmap_pkg::NESTED_VIRT_MEMORY_OFS_TOP_MAP)
    else $error("top register not redirected to memory");
  a_nv_valid_ofs: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    acc_ok && hit_valid && cur_level_i == vpmap_pkg::VPM_EL1 && level2_enabled_i &&
    nested_virt_bit_i && enhanced_nested_bit_i
    |=> resp_result_o == vpmap_pkg::VPM_RES_MEM &&
        resp_mem_offset_o == vpmap_pkg::NESTED_VIRT_MEMORY_OFS_VALID)
    else $error("valid register not redirected to memory");
  a_nv_trap_dest: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    acc_ok && hit_valid && cur_level_i == vpmap_pkg::VPM_EL1 && level2_enabled_i &&
    nested_virt_bit_i && !enhanced_nested_bit_i
    |=> resp_result_o == ($past(trap3) ? vpmap_pkg::VPM_RES_TRAP3 : vpmap_pkg::VPM_RES_TRAP2) &&
        resp_syndrome_o == vpmap_pkg::SYND_CLASS_SYSREG)
    else $error("nested trap wrong for valid register");
  a_nv_top_trap: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    acc_ok && hit_top && cur_level_i == vpmap_pkg::VPM_EL1 && level2_enabled_i &&
    nested_virt_bit_i && !enhanced_nested_bit_i
    |=> resp_result_o == ($past(trap3) ? vpmap_pkg::VPM_RES_TRAP3 : vpmap_pkg::VPM_RES_TRAP2) &&
        resp_syndrome_o == vpmap_pkg::SYND_CLASS_SYSREG)
    else $error("nested trap wrong for top register");
  a_el1_undef: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    acc_ok && cur_level_i == vpmap_pkg::VPM_EL1 && !(level2_enabled_i && nested_virt_bit_i)
    |=> resp_result_o == vpmap_pkg::VPM_RES_UNDEF)
    else $error("level one access without nesting not undefined");
  a_el1_top_kept: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    req_i && cur_level_i == vpmap_pkg::VPM_EL1
    |=> $stable(top_map_reg))
    else $error("level one access changed register");
  a_el2_trap3: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    acc_ok && cur_level_i == vpmap_pkg::VPM_EL2 && trap3
    |=> resp_result_o == vpmap_pkg::VPM_RES_TRAP3 &&
        resp_syndrome_o == vpmap_pkg::SYND_CLASS_SYSREG)
    else $error("level two trap to level three missing");
  a_el2_direct: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    acc_ok && cur_level_i == vpmap_pkg::VPM_EL2 && !trap3
    |=> resp_result_o == vpmap_pkg::VPM_RES_DONE)
    else $error("level two direct access refused");
  a_el3_write: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    acc_ok && req_write_i && hit_top && cur_level_i == vpmap_pkg::VPM_EL3
    |=> top_map_reg == $past(req_wdata_i) && resp_result_o == vpmap_pkg::VPM_RES_DONE)
    else $error("level three write lost");
  a_el3_read: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    acc_ok && !req_write_i && hit_top && cur_level_i == vpmap_pkg::VPM_EL3
    |=> resp_rdata_o == $past(top_map_reg) && resp_result_o == vpmap_pkg::VPM_RES_DONE)
    else $error("level three read wrong");
  a_valid_write: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    acc_ok && req_write_i && hit_valid && cur_level_i == vpmap_pkg::VPM_EL3
    |=> valid_bits == $past(req_wdata_i[vpmap_pkg::VALID_BITS-1:0]))
    else $error("valid register write lost");
  a_valid_rd_zero: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    resp_valid_o && resp_result_o == vpmap_pkg::VPM_RES_DONE && $past(hit_valid)
    |-> resp_rdata_o[DATA_W-1:vpmap_pkg::VALID_BITS] == '0)
    else $error("reserved valid bits not zero");
  a_absent_undef: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    req_i && !reg_present
    |=> resp_result_o == vpmap_pkg::VPM_RES_UNDEF)
    else $error("absent register not undefined");
  a_map_gate: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !level2_enabled_i || !valid_bits[map_vid_i]
    |=> !map_hit_o)
    else $error("mapping hit without enable or valid");
  a_map_enable: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !(map_from_level1_i ? level_one_map_enable_i : level_zero_map_enable_i)
    |=> !map_hit_o)
    else $error("mapping hit while level mapping disabled");
  a_map_range: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    map_vid_i[4:2] != vpmap_pkg::TOP_REG_INDEX[2:0]
    |=> !map_hit_o)
    else $error("mapping hit outside held entries");
  a_map_top_field: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    map_hit_next && map_vid_i[1:0] == 2'h3
    |=> map_physical_id_o == $past(top_map_reg[DATA_W-1 -: vpmap_pkg::FIELD_W]))
    else $error("highest entry not taken from top field");
  a_map_low_field: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    map_hit_next && map_vid_i[1:0] == 2'h0
    |=> map_physical_id_o == $past(top_map_reg[vpmap_pkg::FIELD_W-1:0]))
    else $error("lowest entry not taken from bottom field");
endmodule

// ### tb/vpm_core_model.sv
// core side: one system access per call, fields scrambled once released
module vpm_core_model (
  input wire logic core_clk_i,
  output logic req_o,
  output logic wr_o,
  output logic [15:0] enc_o,
  output logic [63:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req_o = 1'b0;
    wr_o = 1'b0;
    enc_o = 16'h0000;
    wdata_o = 64'h0;
  end
  // idle cycle after each access keeps req a clean pulse
  task automatic access(input logic w, input logic [15:0] e, input logic [63:0] d);
    @(posedge core_clk_i);
    req_o <= 1'b1;
    wr_o <= w;
    enc_o <= e;
    wdata_o <= d;
    @(posedge core_clk_i);
    req_o <= 1'b0;
    wr_o <= ~w;
    enc_o <= ~e;
    wdata_o <= ~d;
  endtask
endmodule

// ### tb/virtual_partition_id_map_access_tb.sv
module virtual_partition_id_map_access_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req, wr, hit, h;
  logic [15:0] enc, pid, pe;
  logic [63:0] wd, rd, top_m, val_m;
  logic [1:0] lvl = 2'h0;
  logic [6:0] c = 7'h00; // l2en l3 trap nv nv2 ext hyp
  logic [4:0] vid = 5'h00;
  logic fl1 = 1'b0, l1e = 1'b0, l0e = 1'b0, rv;
  logic [2:0] res;
  logic [11:0] ofs;
  logic [5:0] syn;
  logic [84:0] q[$];
  int n_fail = 0, num_checks = 0;
  always #2.5 clk = ~clk;
  vpm_core_model vpm_core_model_inst (.core_clk_i(clk), .req_o(req), .wr_o(wr), .enc_o(enc),
    .wdata_o(wd));
  vpm_access vpm_access_inst (.core_clk_i(clk), .sys_rst_i(rst), .req_i(req),
    .req_write_i(wr), .req_op0_i(enc[15:14]), .req_op1_i(enc[13:11]), .req_crn_i(enc[10:7]),
    .req_crm_i(enc[6:3]), .req_op2_i(enc[2:0]), .req_wdata_i(wd), .cur_level_i(lvl),
    .level2_enabled_i(c[6]), .level3_present_i(c[5]), .lower_level_trap_bit_i(c[4]),
    .nested_virt_bit_i(c[3]), .enhanced_nested_bit_i(c[2]), .extension_present_i(c[1]),
    .hyp_control_present_flag_i(c[0]), .level_one_map_enable_i(l1e),
    .level_zero_map_enable_i(l0e), .map_vid_i(vid), .map_from_level1_i(fl1),
    .resp_valid_o(rv), .resp_result_o(res), .resp_rdata_o(rd), .resp_mem_offset_o(ofs),
    .resp_syndrome_o(syn), .map_hit_o(hit), .map_physical_id_o(pid));
  task automatic chk(input logic [84:0] g, input logic [84:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, g, e);
    end
  endtask
  task automatic test_done();
    if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    if (rv === 1'b1) chk({res, rd, ofs, syn}, q.size() ? q.pop_front() : 'x);
  end
  // sel 0 top, 1 valid, 2+b top encoding with bit b flipped
  task automatic acc(input logic [1:0] l, input logic [6:0] cc, input logic w, input int sel);
    logic [2:0] r;
    logic [15:0] e;
    logic [63:0] d;
    d = {$urandom, $urandom};
    e = {vpmap_pkg::OP0_SYS, vpmap_pkg::OP1_HYP, vpmap_pkg::CRN_PART, vpmap_pkg::CRM_TOP_MAP,
      vpmap_pkg::OP2_TOP_MAP};
    if (sel == 1) e[6:0] = {vpmap_pkg::CRM_VALID, vpmap_pkg::OP2_VALID};
    if (sel > 1) e[sel-2] = ~e[sel-2];
    if (cc[1:0] != 2'b11 || l == 2'd0 || sel > 1) r = vpmap_pkg::VPM_RES_UNDEF;
    else if (l == 2'd1) r = !(cc[6] && cc[3]) ? vpmap_pkg::VPM_RES_UNDEF :
      cc[2] ? vpmap_pkg::VPM_RES_MEM : (cc[5] && cc[4]) ? vpmap_pkg::VPM_RES_TRAP3 :
      vpmap_pkg::VPM_RES_TRAP2;
    else if (l == 2'd2 && cc[5] && cc[4]) r = vpmap_pkg::VPM_RES_TRAP3;
    else r = vpmap_pkg::VPM_RES_DONE;
    q.push_back({r, (r == vpmap_pkg::VPM_RES_DONE && !w) ? (sel ? val_m : top_m) : 64'h0,
      r == vpmap_pkg::VPM_RES_MEM ? (sel ? vpmap_pkg::NESTED_VIRT_MEMORY_OFS_VALID :
      vpmap_pkg::NESTED_VIRT_MEMORY_OFS_TOP_MAP) : 12'h000, r >= vpmap_pkg::VPM_RES_TRAP2 ? 6'h18 : 6'h00});
    if (r == vpmap_pkg::VPM_RES_DONE && w) begin
      if (sel) val_m = {32'h0, d[31:0]};
      else top_m = d;
    end
    @(posedge clk);
    lvl <= l;
    c <= cc;
    vpm_core_model_inst.access(w, e, d);
  endtask
  initial begin
    #100us;
    n_fail++;
    test_done();
  end
  initial begin
    void'($urandom(72622));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int s = 0; s < 2; s++) begin
      acc(2'd3, 7'h7f, 1'b1, s);
      acc(2'd3, 7'h7f, 1'b0, s);
      acc(2'd0, 7'h7f, 1'b1, s);
      acc(2'd3, 7'h03, 1'b0, s);
      acc(2'd3, 7'h01, 1'b1, s);
      acc(2'd2, 7'h42, 1'b0, s);
    end
    for (int l = 1; l < 3; l++) begin
      for (int k = 0; k < 32; k++) begin
        acc(l, {k[4:0], 2'h3}, $urandom, $urandom % 2);
      end
    end
    for (int b = 0; b < 16; b++) acc(2'd3, 7'h03, $urandom, b + 2);
    acc(2'd3, 7'h03, 1'b0, 0);
    acc(2'd3, 7'h03, 1'b0, 1);
    for (int k = 0; k < 40; k++) begin
      @(posedge clk);
      vid <= (k < 8) ? 5'd28 + k[1:0] : 5'($urandom);
      fl1 <= $urandom;
      l1e <= $urandom;
      l0e <= $urandom;
      c[6] <= (k < 8) ? 1'b1 : 1'($urandom);
      @(posedge clk);
      @(negedge clk);
      h = vid >= 5'd28 && val_m[vid] && (fl1 ? l1e : l0e) && c[6];
      pe = h ? top_m[16*(int'(vid)-28)+:16] : 16'h0;
      chk({hit, h ? pid : 16'h0}, {h, pe});
    end
    repeat (3) @(posedge clk);
    chk(q.size(), 0);
    test_done();
  end
endmodule
